/* src/eeprom_pkg.sv */
/*
 * Shared constants and types for the serial EEPROM target: address byte
 * layout, page geometry, erased value, program timing and state enums.
 * Assumes a 40 MHz main clock; all users import the whole package.
 */
package eeprom_pkg;

    // Target address byte layout.
    localparam logic [3:0] DEV_PREFIX = 4'ha;
    localparam int DEV_SEL2_BIT = 3;
    localparam int DEV_SEL1_BIT = 2;
    localparam int DEV_SEL0_BIT = 1;
    localparam int DEV_RW_BIT = 0;

    // Array and page geometry.
    localparam int SMALL_ARRAY_BYTES = 256;
    localparam int ARRAY_BYTES_DFLT = 512;
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_BITS = 4;
    localparam logic [4:0] COMMIT_END = 5'h10;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // Longest internal program time and its cycle count, rounded down.
    localparam int PROG_TIME_NS = 5000000;
    localparam int MCLK_PERIOD_NS = 25;
    localparam int PROG_CYCLES_DFLT = PROG_TIME_NS / MCLK_PERIOD_NS;

    // Bit-level position inside a transfer.
    typedef enum logic [3:0] {
        LS_IDLE, LS_DEV, LS_DEV_ACK, LS_WORD, LS_WORD_ACK,
        LS_DATA, LS_DATA_ACK, LS_TX, LS_TX_ACK
    } link_st_t;

    // Progress of the internal program cycle as seen by the link side.
    typedef enum logic [1:0] {
        PH_IDLE, PH_COMMIT, PH_WAIT_HI, PH_WAIT_LO
    } prog_ph_t;

endpackage

/* src/eeprom_mem.sv */
/*
 * Simple dual-port byte memory with one write port and one registered
 * read port, preloaded with a fill value. Both ports share one clock.
 */
`timescale 1ns/10ps
`default_nettype none

module eeprom_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] FILL = '1
) (
    // Clock.
    input wire logic clk,
    // Write port.
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // Read port.
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rd_data_r;

    // Cells start in the erased state, there is no bulk erase.
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = FILL;
        end
    end

    // A read of the address being written returns the old contents.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_r <= mem[rd_addr];
    end

    assign rd_data = rd_data_r;

endmodule
`default_nettype wire

/* src/eeprom_target.sv */
/*
 * Serial EEPROM target: two-wire bus front end, 16-byte page buffer,
 * commit into the array and the internal program timer.
 * Assumes SCL, SDA and the straps are asynchronous pins, the link clock
 * oversamples SCL by far, and the wire level is resolved outside.
 */
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - A page write holds up to 16 bytes, committed in one cycle.
// - Each accepted written byte is acknowledged and bumps only the low four address bits.
// - Beyond sixteen bytes the page offset wraps and overwrites older bytes.
// - The program cycle begins only on STOP after data bytes.
// - While programming, a write-direction address gets no acknowledge.
// - After programming, the write-direction address is acknowledged again.
// - Write protect high blocks writes to the upper half only.
// - Write protect is sampled on the falling edge before the first data byte.
// - Sampled protect high with an upper-half address: first data byte is refused, whole write dropped.
// - Every array byte starts at FFh.
// - A read-direction address is acknowledged, then the current byte is sent.
// - Master refusal of a read byte plus STOP returns to standby.
// - After the dummy write the freshly loaded address is read.
// - Reading continues from consecutive addresses while the master acknowledges.
// - Read addresses cross pages and wrap only at array end.
// - The address byte is 1010, three select bits, then direction; on the large array select bit 0 is address bit 8 instead.
// - During programming, SDA is released and only address refusal happens.
// - Acknowledge pulls SDA low in the ninth clock.
module eeprom_target import eeprom_pkg::*; #(
    parameter int ARRAY_BYTES = ARRAY_BYTES_DFLT,
    parameter int PROG_CYCLES = PROG_CYCLES_DFLT
) (
    // Main clock and synchronous reset.
    input wire logic mclk,
    input wire logic rst_b,
    // Link oversampling clock.
    input wire logic link_clk,
    // Two-wire bus.
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Straps.
    input wire logic chip_select_bit_2,
    input wire logic chip_select_bit_1,
    input wire logic chip_select_bit_0,
    input wire logic write_protect,
    // Status.
    output logic prog_busy
);

    localparam int AW = $clog2(ARRAY_BYTES);
    localparam int TW = $clog2(PROG_CYCLES);
    localparam bit WIDE = (ARRAY_BYTES > SMALL_ARRAY_BYTES);

    // Synchronisers of the link domain.
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic [2:0] pin_s1;
        logic [2:0] pin_s2;
        logic [2:0] cs_s1;
        logic [2:0] cs_s2;
        logic busy_s1;
        logic busy_s2;
    } sync_t;

    // All state of the link domain.
    typedef struct packed {
        sync_t sy;
        logic scl_d;
        logic sda_d;
        link_st_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic rw;
        logic mack;
        logic reject;
        logic [AW-1:0] ptr;
        logic [PAGE_BYTES-1:0] valid;
        logic [AW-PAGE_BITS-1:0] page;
        prog_ph_t ph;
        logic [PAGE_BITS:0] cstep;
        logic aw_en;
        logic [AW-1:0] aw_addr;
        logic bw_en;
        logic [PAGE_BITS-1:0] bw_addr;
        logic [7:0] bw_data;
        logic req_tgl;
        logic sda_o;
        logic sda_oe;
    } link_state_t;

    // All state of the main clock domain.
    typedef struct packed {
        logic tgl_s1;
        logic tgl_s2;
        logic tgl_d;
        logic busy;
        logic [TW-1:0] tmr;
    } main_state_t;

    link_state_t l_r;
    link_state_t l_nxt;
    main_state_t m_r;
    main_state_t m_nxt;
    sync_t sy_nxt;
    logic [7:0] arr_rd;
    logic [7:0] buf_rd;
    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic busy;
    logic rd_msb;

    // Address byte check; the large array frees select bit 0 for addressing.
    function automatic logic dev_match(input logic [7:0] b, input logic [2:0] cs);
        dev_match = (b[7:4] == DEV_PREFIX) && (b[DEV_SEL2_BIT] == cs[2]) &&
                    (b[DEV_SEL1_BIT] == cs[1]) && (WIDE || b[DEV_SEL0_BIT] == cs[0]);
    endfunction

    // Bus events come from the second synchroniser stage and a delayed copy.
    assign scl_s = l_r.sy.pin_s2[2];
    assign sda_s = l_r.sy.pin_s2[1];
    assign wp_s = l_r.sy.pin_s2[0];
    assign scl_rise = scl_s && !l_r.scl_d;
    assign scl_fall = !scl_s && l_r.scl_d;
    assign start_c = scl_s && l_r.scl_d && l_r.sda_d && !sda_s;
    assign stop_c = scl_s && l_r.scl_d && !l_r.sda_d && sda_s;
    assign busy = (l_r.ph != PH_IDLE);
    assign rd_msb = arr_rd[7];

    // Main array; it is only read by the bus side and written by the commit.
    eeprom_mem #(.DEPTH(ARRAY_BYTES), .WIDTH(8), .FILL(ERASED_BYTE)) u_array (
        .clk(link_clk),
        .wr_en(l_r.aw_en),
        .wr_addr(l_r.aw_addr),
        .wr_data(buf_rd),
        .rd_addr(l_r.ptr),
        .rd_data(arr_rd)
    );

    // Page buffer, filled byte by byte and drained only after STOP.
    eeprom_mem #(.DEPTH(PAGE_BYTES), .WIDTH(8), .FILL(ERASED_BYTE)) u_page (
        .clk(link_clk),
        .wr_en(l_r.bw_en),
        .wr_addr(l_r.bw_addr),
        .wr_data(l_r.bw_data),
        .rd_addr(l_r.cstep[PAGE_BITS-1:0]),
        .rd_data(buf_rd)
    );

    // Link domain next state: synchronisers, commit engine, bit engine.
    always_comb begin
        sy_nxt.rst_s1 = rst_b;
        sy_nxt.rst_s2 = l_r.sy.rst_s1;
        sy_nxt.pin_s1 = {scl_i, sda_i, write_protect};
        sy_nxt.pin_s2 = l_r.sy.pin_s1;
        sy_nxt.cs_s1 = {chip_select_bit_2, chip_select_bit_1, chip_select_bit_0};
        sy_nxt.cs_s2 = l_r.sy.cs_s1;
        sy_nxt.busy_s1 = m_r.busy;
        sy_nxt.busy_s2 = l_r.sy.busy_s1;
        l_nxt = l_r;
        l_nxt.sy = sy_nxt;
        l_nxt.scl_d = scl_s;
        l_nxt.sda_d = sda_s;
        l_nxt.aw_en = 1'b0;
        l_nxt.bw_en = 1'b0;
        l_nxt.sda_o = 1'b0;
        // Commit copies the valid bytes of the page in one pass, then waits out the timer.
        unique case (l_r.ph)
            PH_IDLE: begin
            end
            PH_COMMIT: begin
                if (l_r.cstep == COMMIT_END) begin
                    l_nxt.ph = PH_WAIT_HI;
                    l_nxt.req_tgl = !l_r.req_tgl;
                    l_nxt.valid = '0;
                end else begin
                    l_nxt.aw_en = l_r.valid[l_r.cstep[PAGE_BITS-1:0]];
                    l_nxt.aw_addr = {l_r.page, l_r.cstep[PAGE_BITS-1:0]};
                    l_nxt.cstep = l_r.cstep + 1'b1;
                end
            end
            // The handshake stops a poll slipping in before busy is seen.
            PH_WAIT_HI: begin
                if (l_r.sy.busy_s2) begin
                    l_nxt.ph = PH_WAIT_LO;
                end
            end
            PH_WAIT_LO: begin
                if (!l_r.sy.busy_s2) begin
                    l_nxt.ph = PH_IDLE;
                end
            end
        endcase
        if (start_c) begin
            l_nxt.st = LS_DEV;
            l_nxt.cnt = '0;
            l_nxt.sda_oe = 1'b0;
            if (!busy) begin
                l_nxt.valid = '0;
            end
        end else if (stop_c) begin
            l_nxt.st = LS_IDLE;
            l_nxt.sda_oe = 1'b0;
            if (!busy && l_r.valid != '0) begin
                l_nxt.ph = PH_COMMIT;
                l_nxt.cstep = '0;
                l_nxt.page = l_r.ptr[AW-1:PAGE_BITS];
            end
        end else if (scl_rise) begin
            if (l_r.st == LS_DEV || l_r.st == LS_WORD || l_r.st == LS_DATA) begin
                l_nxt.sh = {l_r.sh[6:0], sda_s};
                l_nxt.cnt = l_r.cnt + 1'b1;
            end else if (l_r.st == LS_TX_ACK) begin
                l_nxt.mack = !sda_s;
            end
        end else if (scl_fall) begin
            unique case (l_r.st)
                LS_IDLE: begin
                end
                LS_DEV: begin
                    if (l_r.cnt == BYTE_BITS) begin
                        // While busy the address is refused and SDA stays free.
                        if (dev_match(l_r.sh, l_r.sy.cs_s2) && !busy) begin
                            l_nxt.sda_oe = 1'b1;
                            l_nxt.st = LS_DEV_ACK;
                            l_nxt.rw = l_r.sh[DEV_RW_BIT];
                            if (WIDE) begin
                                l_nxt.ptr[AW-1] = l_r.sh[DEV_SEL0_BIT];
                            end
                        end else begin
                            l_nxt.st = LS_IDLE;
                        end
                    end
                end
                LS_DEV_ACK: begin
                    l_nxt.cnt = '0;
                    if (l_r.rw) begin
                        l_nxt.tx = arr_rd;
                        l_nxt.sda_oe = !arr_rd[7];
                        l_nxt.cnt = 4'h1;
                        l_nxt.st = LS_TX;
                    end else begin
                        l_nxt.sda_oe = 1'b0;
                        l_nxt.st = LS_WORD;
                    end
                end
                LS_WORD: begin
                    if (l_r.cnt == BYTE_BITS) begin
                        l_nxt.sda_oe = 1'b1;
                        l_nxt.ptr[7:0] = l_r.sh;
                        l_nxt.st = LS_WORD_ACK;
                    end
                end
                LS_WORD_ACK: begin
                    l_nxt.sda_oe = 1'b0;
                    l_nxt.cnt = '0;
                    l_nxt.reject = wp_s && l_r.ptr[AW-1];
                    l_nxt.valid = '0;
                    l_nxt.st = LS_DATA;
                end
                LS_DATA: begin
                    if (l_r.cnt == BYTE_BITS) begin
                        if (l_r.reject) begin
                            l_nxt.st = LS_IDLE;
                            l_nxt.valid = '0;
                        end else begin
                            l_nxt.sda_oe = 1'b1;
                            l_nxt.bw_en = 1'b1;
                            l_nxt.bw_addr = l_r.ptr[PAGE_BITS-1:0];
                            l_nxt.bw_data = l_r.sh;
                            l_nxt.valid[l_r.ptr[PAGE_BITS-1:0]] = 1'b1;
                            // Only the page offset counts; it wraps in place.
                            l_nxt.ptr[PAGE_BITS-1:0] = l_r.ptr[PAGE_BITS-1:0] + 1'b1;
                            l_nxt.st = LS_DATA_ACK;
                        end
                    end
                end
                LS_DATA_ACK: begin
                    l_nxt.sda_oe = 1'b0;
                    l_nxt.cnt = '0;
                    l_nxt.st = LS_DATA;
                end
                LS_TX: begin
                    if (l_r.cnt == BYTE_BITS) begin
                        l_nxt.sda_oe = 1'b0;
                        l_nxt.ptr = l_r.ptr + 1'b1;
                        l_nxt.st = LS_TX_ACK;
                    end else begin
                        l_nxt.sda_oe = !l_r.tx[6];
                        l_nxt.tx = {l_r.tx[6:0], 1'b0};
                        l_nxt.cnt = l_r.cnt + 1'b1;
                    end
                end
                LS_TX_ACK: begin
                    if (l_r.mack) begin
                        l_nxt.tx = arr_rd;
                        l_nxt.sda_oe = !arr_rd[7];
                        l_nxt.cnt = 4'h1;
                        l_nxt.st = LS_TX;
                    end else begin
                        l_nxt.st = LS_IDLE;
                    end
                end
            endcase
        end
        // Reset keeps the synchronisers running so that release is seen.
        if (!l_r.sy.rst_s2) begin
            l_nxt = '0;
            l_nxt.sy = sy_nxt;
        end
    end

    always_ff @(posedge link_clk) begin
        l_r <= l_nxt;
    end

    // Main domain: catch the commit toggle and time the program cycle.
    always_comb begin
        m_nxt = m_r;
        m_nxt.tgl_s1 = l_r.req_tgl;
        m_nxt.tgl_s2 = m_r.tgl_s1;
        m_nxt.tgl_d = m_r.tgl_s2;
        if (m_r.busy) begin
            if (m_r.tmr == TW'(PROG_CYCLES - 1)) begin
                m_nxt.busy = 1'b0;
                m_nxt.tmr = '0;
            end else begin
                m_nxt.tmr = m_r.tmr + 1'b1;
            end
        end else if (m_r.tgl_s2 != m_r.tgl_d) begin
            m_nxt.busy = 1'b1;
            m_nxt.tmr = '0;
        end
        if (!rst_b) begin
            m_nxt = '0;
        end
    end

    always_ff @(posedge mclk) begin
        m_r <= m_nxt;
    end

    assign sda_o = l_r.sda_o;
    assign sda_oe = l_r.sda_oe;
    assign prog_busy = m_r.busy;

    // Checks on the link side.
    property p_busy_nack;
        @(posedge link_clk) disable iff (!l_r.sy.rst_s2)
        scl_fall && !start_c && !stop_c && l_r.st == LS_DEV && l_r.cnt == BYTE_BITS && busy
        |=> !sda_oe && l_r.st == LS_IDLE;
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("address acked while busy");

    property p_addr_ack;
        @(posedge link_clk) disable iff (!l_r.sy.rst_s2)
        scl_fall && !start_c && !stop_c && l_r.st == LS_DEV && l_r.cnt == BYTE_BITS &&
        !busy && dev_match(l_r.sh, l_r.sy.cs_s2)
        |=> sda_oe && l_r.st == LS_DEV_ACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("matching address not acked");

    property p_page_wrap;
        @(posedge link_clk) disable iff (!l_r.sy.rst_s2)
        scl_fall && !start_c && !stop_c && l_r.st == LS_DATA && l_r.cnt == BYTE_BITS &&
        !l_r.reject
        |=> sda_oe && l_r.ptr[PAGE_BITS-1:0] == PAGE_BITS'($past(l_r.ptr) + 1'b1) &&
            l_r.ptr[AW-1:PAGE_BITS] == $past(l_r.ptr[AW-1:PAGE_BITS]);
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page offset did not wrap");

    property p_wp_sample;
        @(posedge link_clk) disable iff (!l_r.sy.rst_s2)
        scl_fall && !start_c && !stop_c && l_r.st == LS_WORD_ACK
        |=> l_r.reject == ($past(wp_s) && l_r.ptr[AW-1]);
    endproperty
    a_wp_sample: assert property (p_wp_sample) else $error("protect not sampled");

    property p_wp_reject;
        @(posedge link_clk) disable iff (!l_r.sy.rst_s2)
        scl_fall && !start_c && !stop_c && l_r.st == LS_DATA && l_r.cnt == BYTE_BITS &&
        l_r.reject
        |=> !sda_oe && l_r.st == LS_IDLE && l_r.valid == '0;
    endproperty
    a_wp_reject: assert property (p_wp_reject) else $error("protected write taken");

    property p_commit_run;
        @(posedge link_clk) disable iff (!l_r.sy.rst_s2)
        stop_c && !busy && l_r.valid != '0 |=> l_r.ph == PH_COMMIT ##17 l_r.ph == PH_WAIT_HI;
    endproperty
    a_commit_run: assert property (p_commit_run) else $error("commit did not run");

    property p_commit_cause;
        @(posedge link_clk) disable iff (!l_r.sy.rst_s2)
        $rose(l_r.ph == PH_COMMIT) |-> $past(stop_c);
    endproperty
    a_commit_cause: assert property (p_commit_cause) else $error("commit without stop");

    property p_read_first;
        @(posedge link_clk) disable iff (!l_r.sy.rst_s2)
        scl_fall && !start_c && !stop_c && l_r.st == LS_DEV_ACK && l_r.rw
        |=> l_r.st == LS_TX && sda_oe == !$past(rd_msb);
    endproperty
    a_read_first: assert property (p_read_first) else $error("read byte not started");

    property p_seq_inc;
        @(posedge link_clk) disable iff (!l_r.sy.rst_s2)
        scl_fall && !start_c && !stop_c && l_r.st == LS_TX && l_r.cnt == BYTE_BITS
        |=> !sda_oe && l_r.ptr == AW'($past(l_r.ptr) + 1'b1);
    endproperty
    a_seq_inc: assert property (p_seq_inc) else $error("read address not advanced");

    property p_nack_idle;
        @(posedge link_clk) disable iff (!l_r.sy.rst_s2)
        scl_fall && !start_c && !stop_c && l_r.st == LS_TX_ACK && !l_r.mack
        |=> l_r.st == LS_IDLE && !sda_oe;
    endproperty
    a_nack_idle: assert property (p_nack_idle) else $error("read went on after refusal");

    // The program timer always ends after its full count.
    property p_timer_end;
        @(posedge mclk) disable iff (!rst_b)
        m_r.busy && m_r.tmr == TW'(PROG_CYCLES - 1) |=> !m_r.busy;
    endproperty
    a_timer_end: assert property (p_timer_end) else $error("program timer overran");

    // Main scenarios.
    property p_cov_commit;
        @(posedge link_clk) l_r.ph == PH_COMMIT && l_r.valid == '1;
    endproperty
    c_cov_commit: cover property (p_cov_commit);

    property p_cov_seq;
        @(posedge link_clk) l_r.st == LS_TX_ACK && l_r.mack && scl_fall;
    endproperty
    c_cov_seq: cover property (p_cov_seq);

    property p_cov_reject;
        @(posedge link_clk) l_r.st == LS_DATA && l_r.reject && l_r.cnt == BYTE_BITS;
    endproperty
    c_cov_reject: cover property (p_cov_reject);

    property p_cov_poll;
        @(posedge link_clk) l_r.st == LS_DEV && l_r.cnt == BYTE_BITS && busy && scl_fall;
    endproperty
    c_cov_poll: cover property (p_cov_poll);

endmodule
`default_nettype wire

/* tb/i2c_master_model.sv */
/* Two-wire bus master model that drives the EEPROM target.
   Assumes the bench resolves SDA as a pulled-up wired AND; SCL idles high. */
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
    // Pacing clock.
    input wire logic mclk,
    // Bus pins.
    input wire logic sda,
    output logic scl,
    output logic moe
);
    initial begin
        scl = 1'b1;
        moe = 1'b0;
    end
    // A quarter bit lasts over 8 link periods so the oversampler sees every level.
    task automatic q();
        repeat (2) @(negedge mclk);
    endtask
    // Start or repeated start; polling may follow a stop at once.
    task automatic start();
        moe = 1'b0;
        q();
        scl = 1'b1;
        q();
        moe = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic stop();
        moe = 1'b1;
        q();
        scl = 1'b1;
        q();
        moe = 1'b0;
        q();
    endtask
    // One bit: drive b, sample the wire while SCL is high.
    task automatic bitx(input logic b, output logic r);
        moe = !b;
        q();
        scl = 1'b1;
        q();
        r = sda;
        q();
        scl = 1'b0;
        q();
    endtask
    // Byte out, MSB first, then the target's answer; pages add up to 15 more.
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(output logic [7:0] d, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(!ack, r);
    endtask
endmodule
`default_nettype wire

/* tb/test_i2c_eeprom_page_write_read.sv */
/* Self-checking bench for the EEPROM target with a bus master model.
   Assumes select straps 1,0,0 and a shortened program time. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_i2c_eeprom_page_write_read;
    import eeprom_pkg::*;
    logic mclk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wp = 1'b0;
    logic ack;
    logic [7:0] d;
    logic [7:0] e[$];
    int n_mismatch = 0;
    int check_count = 0;
    wire logic scl, moe, sda_oe, prog_busy, sda, sda_o_w;
    // Open-drain wire with pull-up.
    assign sda = !(sda_oe | moe);
    always #12.5 mclk = ~mclk;
    initial begin
        #1.7;
        forever #3 link_clk = ~link_clk;
    end
    eeprom_target #(.ARRAY_BYTES(512), .PROG_CYCLES(400)) i_eeprom_target (
        .mclk(mclk), .rst_b(rst_b), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o_w), .sda_oe(sda_oe), .chip_select_bit_2(1'b1), .chip_select_bit_1(1'b0),
        .chip_select_bit_0(1'b0), .write_protect(wp), .prog_busy(prog_busy));
    i2c_master_model i_i2c_master_model (.mclk(mclk), .sda(sda), .scl(scl), .moe(moe));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Address byte for straps 1,0 with the top pointer bit.
    function automatic logic [7:0] ab(input logic a8, input logic rd);
        return {DEV_PREFIX, 2'b10, a8, rd};
    endfunction
    // Dummy write that loads the pointer and leaves the frame open.
    task automatic point(input logic [8:0] a);
        i_i2c_master_model.start();
        i_i2c_master_model.wbyte(ab(a[8], 1'b0), ack);
        `CHK(ack, 1'b1)
        i_i2c_master_model.wbyte(a[7:0], ack);
        `CHK(ack, 1'b1)
    endtask
    // Selective then sequential read of the expected bytes in e.
    task automatic rd(input logic [8:0] a);
        point(a);
        i_i2c_master_model.start();
        i_i2c_master_model.wbyte(ab(a[8], 1'b1), ack);
        `CHK(ack, 1'b1)
        foreach (e[i]) begin
            i_i2c_master_model.rbyte(d, i < e.size() - 1);
            `CHK(d, e[i])
        end
        i_i2c_master_model.stop();
    endtask
    // Acknowledge polling with a bounded number of tries.
    task automatic poll(input logic [7:0] adr);
        for (int k = 0; k < 30; k++) begin
            i_i2c_master_model.start();
            i_i2c_master_model.wbyte(adr, ack);
            i_i2c_master_model.stop();
            if (ack) return;
        end
        n_mismatch++;
        report_and_stop();
    endtask
    task automatic t_page();
        point(9'h005);
        for (int i = 0; i < 18; i++) begin
            i_i2c_master_model.wbyte(8'h10 + i[7:0], ack);
            `CHK(ack, 1'b1)
        end
        `CHK(prog_busy, 1'b0)
        i_i2c_master_model.stop();
        i_i2c_master_model.start();
        i_i2c_master_model.wbyte(ab(1'b0, 1'b0), ack);
        `CHK(ack, 1'b0)
        `CHK(prog_busy, 1'b1)
        i_i2c_master_model.stop();
        poll(ab(1'b0, 1'b0));
        e = {};
        for (int o = 0; o < 16; o++) e.push_back(8'h10 + ((o + 11) % 16 < 2 ?
            (o + 11) % 16 + 16 : (o + 11) % 16));
        e.push_back(ERASED_BYTE);
        rd(9'h000);
    endtask
    task automatic t_protect();
        @(negedge mclk) wp = 1'b1;
        point(9'h180);
        i_i2c_master_model.wbyte(8'h55, ack);
        `CHK(ack, 1'b0)
        i_i2c_master_model.stop();
        i_i2c_master_model.start();
        i_i2c_master_model.wbyte(ab(1'b1, 1'b0), ack);
        `CHK(ack, 1'b1)
        i_i2c_master_model.stop();
        point(9'h020);
        i_i2c_master_model.wbyte(8'h5a, ack);
        `CHK(ack, 1'b1)
        i_i2c_master_model.stop();
        poll(ab(1'b0, 1'b0));
        @(negedge mclk) wp = 1'b0;
        e = {8'h5a};
        rd(9'h020);
        e = {ERASED_BYTE};
        rd(9'h180);
    endtask
    task automatic t_wrap_immediate();
        e = {ERASED_BYTE, 8'h1b};
        rd(9'h1ff);
        i_i2c_master_model.start();
        i_i2c_master_model.wbyte(ab(1'b0, 1'b1), ack);
        `CHK(ack, 1'b1)
        i_i2c_master_model.rbyte(d, 1'b0);
        `CHK(d, 8'h1c)
        i_i2c_master_model.stop();
        i_i2c_master_model.start();
        i_i2c_master_model.wbyte({DEV_PREFIX, 2'b01, 1'b0, 1'b0}, ack);
        `CHK(ack, 1'b0)
        i_i2c_master_model.stop();
        `CHK(sda_oe, 1'b0)
        `CHK(sda_o_w, 1'b0)
    endtask
    initial begin
        // Reset spans four main and over four link edges.
        repeat (4) @(negedge mclk);
        rst_b = 1'b1;
        repeat (8) @(negedge mclk);
        e = {ERASED_BYTE};
        rd(9'h0a0);
        t_page();
        t_protect();
        t_wrap_immediate();
        report_and_stop();
    end
endmodule
`default_nettype wire
